// ==== design/dupc_top.v ====
// Two-channel analog output update path control with AXI4-Lite registers.
// Assumes one clock, synchronous trigger and serial link inputs.
// Behaviour
// - Two independent output channels, each loaded with a host-written 16-bit code
// - Each channel has its own range and reference selection bits
// - Immediate mode applies a newly written code at once
// - Posted mode transfers buffered codes on a low pulse of the trigger input
// - Posted mode also transfers buffered codes on an update register write
// - Unipolar channel treats its code as straight binary
// - Bipolar channel treats its code as two's complement
// - Each channel has software-loaded 8-bit offset and gain calibration values
// - Calibration memory refuses writes to locations 96 to 127
// - Calibration memory locations 0 to 95 stay writable
// - Immediate mode holds the active-low converter update strobe asserted
// - Immediate mode feeds converters only from the local latch
// - Software output mode setting selects the data path
// - Posted mode FIFO buffers up to 2048 host values
// - Serial link latch holds one received value ahead of each update
// - Posted mode allows FIFO and local latch together or separately
// - Posted local latch value reaches converter only at next update
// - Serial link latch path excludes all other paths
// - Each posted FIFO update pops one value onto the converter
// - Write request means not full or less than half full, by setting
// - FIFO empty at an update stops FIFO updates until the flag is cleared and sets underflow flag; local latch still updates
`include "dupc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module dupc_top (
  // Clock and reset
  input wire REF_CLK,
  input wire ARST_N,
  // AXI4-Lite write address
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  // AXI4-Lite write response
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // AXI4-Lite read address
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Update trigger and serial link
  input wire TIMER_UPDATE_TRIGGER_N,
  input wire SERIAL_LINK_BIT,
  input wire SERIAL_LINK_STROBE,
  // Converter side
  output reg [15:0] DAC0_CODE,
  output reg [15:0] DAC1_CODE,
  output wire DAC_UPDATE_N,
  output reg DAC0_BIPOLAR,
  output reg DAC1_BIPOLAR,
  output reg DAC0_EXTERNAL_REFERENCE,
  output reg DAC1_EXTERNAL_REFERENCE,
  output reg [7:0] DAC0_OFFSET_CAL,
  output reg [7:0] DAC0_GAIN_CAL,
  output reg [7:0] DAC1_OFFSET_CAL,
  output reg [7:0] DAC1_GAIN_CAL,
  // Status
  output reg OUTPUT_WRITE_REQUEST,
  output reg WAVEFORM_UNDERFLOW
);

  // Merge write data into a register under byte strobes
  function [31:0] dupc_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] st;
    integer i;
    begin
      dupc_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          dupc_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // Straight-binary converter code from channel code
  function [15:0] dupc_fmt;
    input [15:0] code;
    input bipolar;
    begin
      dupc_fmt = {code[15] ^ bipolar, code[14:0]};
    end
  endfunction

  reg rst_meta;
  reg rst_n;
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Control and data registers
  reg [`DUPC_CTRL_W-1:0] ctrl;
  reg [15:0] local0;
  reg [15:0] local1;
  reg [31:0] cal;
  reg [6:0] ee_addr;
  reg ee_refused;
  reg [7:0] ee_mem [0:`DUPC_EE_WORDS-1];

  wire posted = ctrl[`DUPC_CTRL_POSTED];
  wire fifo_en = ctrl[`DUPC_CTRL_FIFO_EN];
  wire local_en = ctrl[`DUPC_CTRL_LOCAL_EN];
  wire serial_en = ctrl[`DUPC_CTRL_SERIAL_EN];

  // Write channel capture
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  wire wr_go = aw_held && w_held && !S_AXI_BVALID;
  wire wr_ctrl = wr_go && aw_addr == `DUPC_CTRL_OFF;
  wire wr_d0 = wr_go && aw_addr == `DUPC_DATA0_OFF;
  wire wr_d1 = wr_go && aw_addr == `DUPC_DATA1_OFF;
  wire wr_fifo = wr_go && aw_addr == `DUPC_FIFO_OFF;
  wire wr_upd = wr_go && aw_addr == `DUPC_UPDATE_OFF;
  wire wr_stat = wr_go && aw_addr == `DUPC_STATUS_OFF;
  wire wr_cal = wr_go && aw_addr == `DUPC_CAL_OFF;
  wire wr_ee = wr_go && aw_addr == `DUPC_EEPROM_OFF;
  reg wr_mapped;
  always @* begin
    if (aw_addr == `DUPC_CTRL_OFF || aw_addr == `DUPC_DATA0_OFF) begin
      wr_mapped = 1'b1;
    end else if (aw_addr == `DUPC_DATA1_OFF || aw_addr == `DUPC_FIFO_OFF) begin
      wr_mapped = 1'b1;
    end else if (aw_addr == `DUPC_UPDATE_OFF || aw_addr == `DUPC_STATUS_OFF) begin
      wr_mapped = 1'b1;
    end else if (aw_addr == `DUPC_CAL_OFF || aw_addr == `DUPC_EEPROM_OFF) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end
  wire [31:0] wmerged_ctrl = dupc_merge({{(32-`DUPC_CTRL_W){1'b0}}, ctrl}, w_data, w_strb);
  wire [31:0] wmerged_d0 = dupc_merge({16'h0000, local0}, w_data, w_strb);
  wire [31:0] wmerged_d1 = dupc_merge({16'h0000, local1}, w_data, w_strb);

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `DUPC_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_mapped ? `DUPC_RESP_OKAY : `DUPC_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Trigger synchroniser and falling-edge detect
  reg trig_meta;
  reg trig_sync;
  reg trig_last;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      trig_meta <= 1'b1;
      trig_sync <= 1'b1;
      trig_last <= 1'b1;
    end else begin
      trig_meta <= TIMER_UPDATE_TRIGGER_N;
      trig_sync <= trig_meta;
      trig_last <= trig_sync;
    end
  end
  wire trig_event = trig_last && !trig_sync;
  wire upd_strobe = wr_upd && w_strb != 4'h0;
  wire update_event = posted && (trig_event || upd_strobe);

  // Waveform FIFO, entries carry a channel bit
  reg [16:0] fifo_mem [0:`DUPC_FIFO_DEPTH-1];
  reg [`DUPC_FIFO_AW-1:0] wr_ptr;
  reg [`DUPC_FIFO_AW-1:0] rd_ptr;
  reg [`DUPC_FIFO_AW:0] count;
  wire fifo_empty = count == {(`DUPC_FIFO_AW+1){1'b0}};
  wire fifo_full = count == `DUPC_FIFO_DEPTH;
  wire fifo_push = wr_fifo && !fifo_full && w_strb[1:0] == 2'b11;
  wire fifo_path = fifo_en && !serial_en;
  wire fifo_pop = update_event && fifo_path && !fifo_empty && !WAVEFORM_UNDERFLOW;
  wire [16:0] fifo_head = fifo_mem[rd_ptr];
  always @(posedge REF_CLK) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr] <= w_data[16:0];
    end
  end
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {`DUPC_FIFO_AW{1'b0}};
      rd_ptr <= {`DUPC_FIFO_AW{1'b0}};
      count <= {(`DUPC_FIFO_AW+1){1'b0}};
    end else begin
      if (fifo_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (fifo_push && !fifo_pop) begin
        count <= count + 1'b1;
      end else if (fifo_pop && !fifo_push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Serial link latch, MSB first, one value held
  reg [15:0] ser_shift;
  reg [4:0] ser_bits;
  reg [15:0] ser_value;
  reg ser_full;
  wire ser_done = SERIAL_LINK_STROBE && ser_bits == `DUPC_SER_BITS - 5'h01;
  wire ser_take = update_event && serial_en && ser_full;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ser_shift <= `DUPC_CODE_RST;
      ser_bits <= 5'h00;
      ser_value <= `DUPC_CODE_RST;
      ser_full <= 1'b0;
    end else begin
      if (SERIAL_LINK_STROBE) begin
        ser_shift <= {ser_shift[14:0], SERIAL_LINK_BIT};
        ser_bits <= ser_done ? 5'h00 : ser_bits + 5'h01;
      end
      if (ser_done) begin
        ser_value <= {ser_shift[14:0], SERIAL_LINK_BIT};
        ser_full <= 1'b1;
      end else if (ser_take) begin
        ser_full <= 1'b0;
      end
    end
  end

  // Control, local latches, calibration, underflow
  wire underflow_hit = update_event && fifo_path && fifo_empty;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DUPC_CTRL_RST;
      local0 <= `DUPC_CODE_RST;
      local1 <= `DUPC_CODE_RST;
      cal <= `DUPC_CAL_RST;
      WAVEFORM_UNDERFLOW <= 1'b0;
      ee_addr <= 7'h00;
      ee_refused <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wmerged_ctrl[`DUPC_CTRL_W-1:0];
      end
      if (wr_d0) begin
        local0 <= wmerged_d0[15:0];
      end
      if (wr_d1) begin
        local1 <= wmerged_d1[15:0];
      end
      if (wr_cal) begin
        cal <= dupc_merge(cal, w_data, w_strb);
      end
      if (underflow_hit) begin
        WAVEFORM_UNDERFLOW <= 1'b1;
      end else if (wr_stat && w_strb[0] && w_data[`DUPC_ST_UNDERFLOW]) begin
        WAVEFORM_UNDERFLOW <= 1'b0;
      end
      if (wr_ee && w_strb[0]) begin
        ee_addr <= w_data[6:0];
      end
      if (wr_ee && w_strb[3] && w_data[`DUPC_EE_WRITE]) begin
        ee_refused <= w_data[6:0] >= `DUPC_EE_PROT_FIRST;
      end
    end
  end

  // Calibration memory, factory area write-protected
  always @(posedge REF_CLK) begin
    if (wr_ee && w_strb[3] && w_data[`DUPC_EE_WRITE] && w_data[6:0] < `DUPC_EE_PROT_FIRST) begin
      ee_mem[w_data[6:0]] <= w_data[`DUPC_EE_DATA_LSB +: 8];
    end
  end

  // Converter codes
  reg upd_pulse;
  assign DAC_UPDATE_N = posted ? !upd_pulse : 1'b0;
  wire [15:0] d0_imm = local0;
  wire [15:0] d1_imm = local1;
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DAC0_CODE <= `DUPC_CODE_RST;
      DAC1_CODE <= `DUPC_CODE_RST;
      upd_pulse <= 1'b0;
      DAC0_BIPOLAR <= 1'b0;
      DAC1_BIPOLAR <= 1'b0;
      DAC0_EXTERNAL_REFERENCE <= 1'b0;
      DAC1_EXTERNAL_REFERENCE <= 1'b0;
      DAC0_OFFSET_CAL <= 8'h00;
      DAC0_GAIN_CAL <= 8'h00;
      DAC1_OFFSET_CAL <= 8'h00;
      DAC1_GAIN_CAL <= 8'h00;
      OUTPUT_WRITE_REQUEST <= 1'b0;
    end else begin
      DAC0_BIPOLAR <= ctrl[`DUPC_CTRL_BIP0];
      DAC1_BIPOLAR <= ctrl[`DUPC_CTRL_BIP1];
      DAC0_EXTERNAL_REFERENCE <= ctrl[`DUPC_CTRL_EXT0];
      DAC1_EXTERNAL_REFERENCE <= ctrl[`DUPC_CTRL_EXT1];
      DAC0_OFFSET_CAL <= cal[7:0];
      DAC0_GAIN_CAL <= cal[15:8];
      DAC1_OFFSET_CAL <= cal[23:16];
      DAC1_GAIN_CAL <= cal[31:24];
      OUTPUT_WRITE_REQUEST <= posted && fifo_path &&
        (ctrl[`DUPC_CTRL_REQ_HALF] ? count < `DUPC_FIFO_HALF : !fifo_full);
      // Local latch still applies while the FIFO path is starved
      upd_pulse <= update_event && (!fifo_path || fifo_pop || local_en);
      if (!posted) begin
        DAC0_CODE <= dupc_fmt(d0_imm, ctrl[`DUPC_CTRL_BIP0]);
        DAC1_CODE <= dupc_fmt(d1_imm, ctrl[`DUPC_CTRL_BIP1]);
      end else if (update_event) begin
        if (serial_en) begin
          if (ser_full && !ctrl[`DUPC_CTRL_SER_CH]) begin
            DAC0_CODE <= dupc_fmt(ser_value, ctrl[`DUPC_CTRL_BIP0]);
          end
          if (ser_full && ctrl[`DUPC_CTRL_SER_CH]) begin
            DAC1_CODE <= dupc_fmt(ser_value, ctrl[`DUPC_CTRL_BIP1]);
          end
        end else begin
          if (local_en) begin
            DAC0_CODE <= dupc_fmt(local0, ctrl[`DUPC_CTRL_BIP0]);
            DAC1_CODE <= dupc_fmt(local1, ctrl[`DUPC_CTRL_BIP1]);
          end
          if (fifo_pop && !fifo_head[`DUPC_FIFO_CH]) begin
            DAC0_CODE <= dupc_fmt(fifo_head[15:0], ctrl[`DUPC_CTRL_BIP0]);
          end
          if (fifo_pop && fifo_head[`DUPC_FIFO_CH]) begin
            DAC1_CODE <= dupc_fmt(fifo_head[15:0], ctrl[`DUPC_CTRL_BIP1]);
          end
        end
      end
    end
  end

  // Read channel
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire [7:0] ar = {S_AXI_ARADDR[7:2], 2'b00};
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `DUPC_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= `DUPC_RESP_OKAY;
      S_AXI_RDATA <= 32'h0000_0000;
      if (ar == `DUPC_CTRL_OFF) begin
        S_AXI_RDATA <= {{(32-`DUPC_CTRL_W){1'b0}}, ctrl};
      end else if (ar == `DUPC_DATA0_OFF) begin
        S_AXI_RDATA <= {16'h0000, local0};
      end else if (ar == `DUPC_DATA1_OFF) begin
        S_AXI_RDATA <= {16'h0000, local1};
      end else if (ar == `DUPC_FIFO_OFF || ar == `DUPC_UPDATE_OFF) begin
        S_AXI_RDATA <= 32'h0000_0000;
      end else if (ar == `DUPC_STATUS_OFF) begin
        S_AXI_RDATA <= {4'h0, count, 12'h000, OUTPUT_WRITE_REQUEST, fifo_full,
          fifo_empty, WAVEFORM_UNDERFLOW};
      end else if (ar == `DUPC_CAL_OFF) begin
        S_AXI_RDATA <= cal;
      end else if (ar == `DUPC_EEPROM_OFF) begin
        S_AXI_RDATA <= {1'b0, ee_refused, 14'h0000, ee_mem[ee_addr], 1'b0, ee_addr};
      end else begin
        S_AXI_RRESP <= `DUPC_RESP_SLVERR;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== common/dupc_defs.vh ====
// Constants for the analog output update path control block.
// Assumes byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef DUPC_DEFS_VH
`define DUPC_DEFS_VH

// Register byte offsets
`define DUPC_CTRL_OFF 8'h00
`define DUPC_DATA0_OFF 8'h04
`define DUPC_DATA1_OFF 8'h08
`define DUPC_FIFO_OFF 8'h0C
`define DUPC_UPDATE_OFF 8'h10
`define DUPC_STATUS_OFF 8'h14
`define DUPC_CAL_OFF 8'h18
`define DUPC_EEPROM_OFF 8'h1C

// Control register fields
`define DUPC_CTRL_POSTED 0
`define DUPC_CTRL_FIFO_EN 1
`define DUPC_CTRL_LOCAL_EN 2
`define DUPC_CTRL_SERIAL_EN 3
`define DUPC_CTRL_REQ_HALF 4
`define DUPC_CTRL_BIP0 5
`define DUPC_CTRL_EXT0 6
`define DUPC_CTRL_BIP1 7
`define DUPC_CTRL_EXT1 8
`define DUPC_CTRL_SER_CH 9
`define DUPC_CTRL_W 10
`define DUPC_CTRL_RST 10'h000

// FIFO entry and status fields
`define DUPC_FIFO_CH 16
`define DUPC_ST_UNDERFLOW 0
`define DUPC_ST_EMPTY 1
`define DUPC_ST_FULL 2
`define DUPC_ST_REQ 3
`define DUPC_ST_COUNT_LSB 16

// EEPROM register fields
`define DUPC_EE_WRITE 31
`define DUPC_EE_REFUSED 30
`define DUPC_EE_DATA_LSB 8
`define DUPC_EE_WORDS 128
`define DUPC_EE_PROT_FIRST 7'h60

// Sizes and reset values
`define DUPC_FIFO_DEPTH 2048
`define DUPC_FIFO_AW 11
`define DUPC_FIFO_HALF 12'h400
`define DUPC_CODE_RST 16'h0000
`define DUPC_CAL_RST 32'h8080_8080
`define DUPC_SER_BITS 5'h10

// AXI responses
`define DUPC_RESP_OKAY 2'b00
`define DUPC_RESP_SLVERR 2'b10

`endif

// ==== bench/dupc_top_sva_sv_checker_sva.sv ====
// Concurrent checks on the output update path control ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dupc_top_sva (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Register bus
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // Converter side and status
  input wire logic [15:0] DAC0_CODE,
  input wire logic [15:0] DAC1_CODE,
  input wire logic DAC_UPDATE_N,
  input wire logic DAC0_BIPOLAR,
  input wire logic DAC1_EXTERNAL_REFERENCE,
  input wire logic WAVEFORM_UNDERFLOW
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  a_code0_gated: assert property ($changed(DAC0_CODE) |-> !DAC_UPDATE_N)
    else $error("DAC0 code moved with update strobe idle");
  a_code1_gated: assert property ($changed(DAC1_CODE) |-> !DAC_UPDATE_N)
    else $error("DAC1 code moved with update strobe idle");
  a_uflow_sticky: assert property (WAVEFORM_UNDERFLOW && !S_AXI_WVALID && !$past(S_AXI_WVALID)
    && !S_AXI_BVALID |=> WAVEFORM_UNDERFLOW)
    else $error("Underflow flag cleared without a write");
  a_bipolar_cause: assert property ($changed(DAC0_BIPOLAR) |-> S_AXI_BVALID || $past(S_AXI_BVALID))
    else $error("Range select changed without a write");
  a_external_reference_input_cause: assert property ($changed(DAC1_EXTERNAL_REFERENCE)
    |-> S_AXI_BVALID || $past(S_AXI_BVALID))
    else $error("Reference select changed without a write");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped early");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("Read data dropped early");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("Read answer late");
  c_underflow: cover property ($rose(WAVEFORM_UNDERFLOW));
  c_posted_pulse: cover property ($rose(DAC_UPDATE_N) ##[1:50] $fell(DAC_UPDATE_N));
  c_code1_move: cover property ($changed(DAC1_CODE));
endmodule
`default_nettype wire

// ==== bench/dupc_far_side.sv ====
// Far-side model: timer trigger source and serial link sender.
// Assumes the same clock as the block; changes just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module dupc_far_side (
  // Clock
  input wire logic clk,
  // Trigger and serial link
  output logic trig_n,
  output logic ser_bit,
  output logic ser_stb
);
  initial begin
    trig_n = 1'b1;
    ser_bit = 1'b0;
    ser_stb = 1'b0;
  end
  // Low pulse of w cycles, then idle high while the event lands
  task automatic pulse(input int w);
    @(posedge clk);
    trig_n <= 1'b0;
    repeat (w) @(posedge clk);
    trig_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // MSB first, one strobe per bit; line shows junk between strobes
  task automatic send(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      ser_bit <= v[i];
      ser_stb <= 1'b1;
      @(posedge clk);
      ser_stb <= 1'b0;
      ser_bit <= ~v[i];
    end
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/test_dac_update_path_control.sv ====
// Self-checking bench for the output update path control block.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_dac_update_path_control;
  logic REF_CLK = 1'b0;
  logic ARST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] bresp, rresp;
  logic [31:0] rv;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID, S_AXI_RVALID, DAC_UPDATE_N;
  wire DAC0_BIPOLAR, DAC1_BIPOLAR, DAC0_EXTERNAL_REFERENCE, DAC1_EXTERNAL_REFERENCE;
  wire OUTPUT_WRITE_REQUEST, WAVEFORM_UNDERFLOW;
  wire TIMER_UPDATE_TRIGGER_N, SERIAL_LINK_BIT, SERIAL_LINK_STROBE;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [15:0] DAC0_CODE, DAC1_CODE;
  wire [7:0] DAC0_OFFSET_CAL, DAC0_GAIN_CAL, DAC1_OFFSET_CAL, DAC1_GAIN_CAL;
  int errors = 0;
  int checked = 0;
  always #2 REF_CLK = ~REF_CLK;
  dupc_top dut (.REF_CLK, .ARST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .TIMER_UPDATE_TRIGGER_N, .SERIAL_LINK_BIT,
    .SERIAL_LINK_STROBE, .DAC0_CODE, .DAC1_CODE, .DAC_UPDATE_N, .DAC0_BIPOLAR, .DAC1_BIPOLAR,
    .DAC0_EXTERNAL_REFERENCE, .DAC1_EXTERNAL_REFERENCE, .DAC0_OFFSET_CAL, .DAC0_GAIN_CAL,
    .DAC1_OFFSET_CAL, .DAC1_GAIN_CAL, .OUTPUT_WRITE_REQUEST, .WAVEFORM_UNDERFLOW);
  dupc_far_side far (.clk(REF_CLK), .trig_n(TIMER_UPDATE_TRIGGER_N), .ser_bit(SERIAL_LINK_BIT),
    .ser_stb(SERIAL_LINK_STROBE));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ka, kw, b;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge REF_CLK);
      ka = S_AXI_AWREADY;
      kw = S_AXI_WREADY;
      b = S_AXI_BVALID;
      bresp = S_AXI_BRESP;
      @(posedge REF_CLK);
      if (ka) S_AXI_AWVALID <= 1'b0;
      if (kw) S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [7:0] a);
    logic k, v;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge REF_CLK);
      k = S_AXI_ARREADY;
      v = S_AXI_RVALID;
      rv = S_AXI_RDATA;
      rresp = S_AXI_RRESP;
      @(posedge REF_CLK);
      if (k) S_AXI_ARVALID <= 1'b0;
    end
    S_AXI_RREADY <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic t_immediate;
    wr(8'h04, 32'h0000_1234);
    wr(8'h08, 32'h0000_ABCD);
    chk("cal_reset", {DAC1_GAIN_CAL, DAC1_OFFSET_CAL, DAC0_GAIN_CAL, DAC0_OFFSET_CAL},
      32'h8080_8080);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_1234);
    chk("dac1", 32'(DAC1_CODE), 32'h0000_ABCD);
    chk("update_n", 32'(DAC_UPDATE_N), 32'h0000_0000);
    far.send(16'hF0F0);
    far.pulse(2);
    wr(8'h10, 32'h0000_0001);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_1234);
  endtask
  task automatic t_config;
    wr(8'h00, 32'h0000_0120);
    chk("sel", {DAC1_EXTERNAL_REFERENCE, DAC1_BIPOLAR, DAC0_EXTERNAL_REFERENCE, DAC0_BIPOLAR},
      32'h0000_0009);
    wr(8'h04, 32'h0000_8001);
    wr(8'h08, 32'h0000_8001);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_0001);
    chk("dac1", 32'(DAC1_CODE), 32'h0000_8001);
    rd(8'h04);
    chk("data0", rv, 32'h0000_8001);
    wr(8'h18, 32'h4433_2211);
    chk("cal", {DAC1_GAIN_CAL, DAC1_OFFSET_CAL, DAC0_GAIN_CAL, DAC0_OFFSET_CAL},
      32'h4433_2211);
    wr(8'h18, 32'hFFFF_FF77, 4'h1);
    chk("cal_byte", {DAC1_GAIN_CAL, DAC1_OFFSET_CAL, DAC0_GAIN_CAL, DAC0_OFFSET_CAL},
      32'h4433_2277);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_2468);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_2468);
  endtask
  task automatic t_posted_local;
    wr(8'h00, 32'h0000_0005);
    wr(8'h04, 32'h0000_1111);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_2468);
    chk("update_n", 32'(DAC_UPDATE_N), 32'h0000_0001);
    wr(8'h10, 32'h0000_0001);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_1111);
    wr(8'h04, 32'h0000_3333);
    far.pulse(4);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_3333);
  endtask
  task automatic t_fifo;
    wr(8'h00, 32'h0000_0003);
    rd(8'h14);
    chk("status", rv, 32'h0000_000A);
    wr(8'h0C, 32'h0000_0101);
    wr(8'h0C, 32'h0000_0202);
    wr(8'h0C, 32'h0001_0303);
    wr(8'h0C, 32'h0000_0404, 4'h1);
    far.pulse(6);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_0101);
    rd(8'h14);
    chk("status", rv, 32'h0002_0008);
    far.pulse(1);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_0202);
    wr(8'h10, 32'h0000_0100, 4'h2);
    chk("dac1", 32'(DAC1_CODE), 32'h0000_0303);
    far.pulse(1);
    chk("underflow", 32'(WAVEFORM_UNDERFLOW), 32'h0000_0001);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_0202);
    wr(8'h14, 32'h0000_0001);
    chk("underflow", 32'(WAVEFORM_UNDERFLOW), 32'h0000_0000);
    wr(8'h00, 32'h0000_0007);
    wr(8'h08, 32'h0000_5A5A);
    wr(8'h0C, 32'h0000_0707);
    wr(8'h10, 32'h0000_0001);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_0707);
    chk("dac1", 32'(DAC1_CODE), 32'h0000_5A5A);
  endtask
  task automatic t_fill;
    wr(8'h00, 32'h0000_0013);
    for (int i = 0; i < 2048; i++) begin
      wr(8'h0C, 32'(i));
      if (i == 1022) chk("req_half", 32'(OUTPUT_WRITE_REQUEST), 32'h0000_0001);
      if (i == 1023) chk("req_half", 32'(OUTPUT_WRITE_REQUEST), 32'h0000_0000);
    end
    wr(8'h00, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0999);
    rd(8'h14);
    chk("status", rv, 32'h0800_0004);
    wr(8'h10, 32'h0000_0001);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_0000);
    chk("req", 32'(OUTPUT_WRITE_REQUEST), 32'h0000_0001);
  endtask
  task automatic t_serial;
    wr(8'h00, 32'h0000_020D);
    wr(8'h04, 32'h0000_4444);
    far.send(16'hBEEF);
    far.pulse(2);
    chk("dac1", 32'(DAC1_CODE), 32'h0000_BEEF);
    chk("dac0", 32'(DAC0_CODE), 32'h0000_0000);
    rd(8'h14);
    chk("status", rv, 32'h07FF_0000);
    far.send(16'h0F0F);
    far.send(16'hC3C3);
    wr(8'h10, 32'h0000_0001);
    chk("dac1", 32'(DAC1_CODE), 32'h0000_C3C3);
  endtask
  task automatic t_eeprom;
    logic [6:0] ad [4];
    ad = '{7'd5, 7'd95, 7'd96, 7'd127};
    for (int i = 0; i < 4; i++) begin
      wr(8'h1C, {1'b1, 15'h0000, 8'hA5, 1'b0, ad[i]});
      rd(8'h1C);
      chk("refused", 32'(rv[30]), 32'(ad[i] > 7'd95));
      if (i < 2) chk("ee_data", 32'(rv[15:8]), 32'h0000_00A5);
      else chk("ee_kept", 32'(rv[15:8] === 8'hA5), 32'h0000_0000);
    end
    wr(8'h20, 32'h0000_0001);
    chk("bresp", 32'(bresp), 32'h0000_0002);
    rd(8'h20);
    chk("rresp", 32'(rresp), 32'h0000_0002);
  endtask
  task automatic t_reset;
    ARST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    chk("cal_reset", {DAC1_GAIN_CAL, DAC1_OFFSET_CAL, DAC0_GAIN_CAL, DAC0_OFFSET_CAL},
      32'h8080_8080);
    chk("dac1_reset", 32'(DAC1_CODE), 32'h0000_0000);
    chk("update_n", 32'(DAC_UPDATE_N), 32'h0000_0000);
  endtask
  task automatic give_verdict;
    $display("Checks run %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge REF_CLK);
    errors++;
    give_verdict;
  end
  initial begin
    ARST_N = 1'b0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0000_0000;
    S_AXI_WSTRB = 4'hF;
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    t_immediate;
    t_config;
    t_posted_local;
    t_fifo;
    t_fill;
    t_serial;
    t_reset;
    t_eeprom;
    give_verdict;
  end
endmodule
bind dupc_top dupc_top_sva sva_i (.REF_CLK, .ARST_N, .S_AXI_WVALID, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
  .S_AXI_RDATA, .DAC0_CODE, .DAC1_CODE, .DAC_UPDATE_N, .DAC0_BIPOLAR,
  .DAC1_EXTERNAL_REFERENCE, .WAVEFORM_UNDERFLOW);
`default_nettype wire
